//--- include/lbsc_map.vh
// Constants for the loopback signature capture block.
// Included by the signature register and capture files (not the synchroniser); holds definitions only.
`ifndef LBSC_MAP_VH
`define LBSC_MAP_VH

// ----------------------------------------------------------------
// Group widths (signals per group) and total pin synchroniser width
// ----------------------------------------------------------------
`define LBSC_CA_N 13
`define LBSC_D_N 10
`define LBSC_SYNC_W 29

// ----------------------------------------------------------------
// Capture mode codes (command/address and data share them)
// ----------------------------------------------------------------
`define LBSC_MODE_PRESET 3'h0
`define LBSC_MODE_REG 3'h2
`define LBSC_MODE_SIG 3'h3

// ----------------------------------------------------------------
// Preset values: rising bits 0, falling bits 1
// ----------------------------------------------------------------
`define LBSC_CA_PRESET 26'h2AAAAAA
`define LBSC_D_PRESET 20'hAAAAA

// ----------------------------------------------------------------
// Compressor feedback tap (second bit below the top)
// ----------------------------------------------------------------
`define LBSC_TAP_OFS 2

// ----------------------------------------------------------------
// Read-back select codes
// ----------------------------------------------------------------
`define LBSC_RB_SIG 2'h1
`define LBSC_RB_RX 2'h2
`define LBSC_RB_STICKY 2'h3

// ----------------------------------------------------------------
// Test port instruction codes
// ----------------------------------------------------------------
`define LBSC_TP_STICKY 2'h0
`define LBSC_TP_MASK 2'h1
`define LBSC_TP_CA_SIG 2'h2
`define LBSC_TP_D_SIG 2'h3

// ----------------------------------------------------------------
// Mask word layout in the test port data
// ----------------------------------------------------------------
`define LBSC_MASK_CA_LSB 0
`define LBSC_MASK_D_LSB 13

`endif

//--- hdl/lbsc_sync.v
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes inputs are asynchronous to clk; output changes only
// once the second and third stages agree.
`timescale 1ns/1ns
module lbsc_sync #(
  parameter W = 1
) (
  input wire clk, // core clock
  input wire rst, // async reset, active high
  input wire [W-1:0] din, // asynchronous pin levels
  output reg [W-1:0] dout_q // filtered synchronous levels
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  wire [W-1:0] agree;
  wire [W-1:0] dout_d;

  assign agree = ~(s2_q ^ s3_q);
  assign dout_d = (agree & s3_q) | (~agree & dout_q);

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
      dout_q <= {W{1'b0}};
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      dout_q <= dout_d;
    end
  end
endmodule // lbsc_sync

//--- hdl/lbsc_sig_reg.v
// Per-signal signature register: preset, compress or raw store.
// Assumes rise and fall strobes are single-cycle core-clock pulses
// and that inputs are already masked by the caller.
`timescale 1ns/1ns
`include "lbsc_map.vh"
module lbsc_sig_reg #(
  parameter N = 10,
  parameter [2*N-1:0] PRESET = {N{2'b10}}
) (
  input wire clk, // core clock
  input wire rst, // async reset, active high
  input wire preset, // load preset value
  input wire sigMode, // compress captured values
  input wire regMode, // store raw values
  input wire riseEn, // true-edge sample pulse
  input wire fallEn, // complement-edge sample pulse
  input wire [N-1:0] riseIn, // values at true edge
  input wire [N-1:0] fallIn, // values at complement edge
  output reg [2*N-1:0] sig_q // register contents
);
  reg [2*N-1:0] sig_d;
  reg fb;
  integer i;

  always @*
  begin
    sig_d = sig_q;
    fb = 1'b0;
    if (riseEn && regMode)
    begin
      for (i = 0; i < N; i = i + 1)
        sig_d[2*i] = riseIn[i];
    end
    if (fallEn && regMode)
    begin
      for (i = 0; i < N; i = i + 1)
        sig_d[2*i+1] = fallIn[i];
    end
    if (riseEn && sigMode)
    begin
      fb = sig_d[2*N-1] ^ sig_d[2*N-1-`LBSC_TAP_OFS];
      sig_d = {sig_d[2*N-2:0], fb};
      for (i = 0; i < N; i = i + 1)
        sig_d[2*i] = sig_d[2*i] ^ riseIn[i];
    end
    if (fallEn && sigMode)
    begin
      fb = sig_d[2*N-1] ^ sig_d[2*N-1-`LBSC_TAP_OFS];
      sig_d = {sig_d[2*N-2:0], fb};
      for (i = 0; i < N; i = i + 1)
        sig_d[2*i+1] = sig_d[2*i+1] ^ fallIn[i];
    end
    if (preset)
      sig_d = PRESET;
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
      sig_q <= PRESET;
    else
      sig_q <= sig_d;
  end
endmodule // lbsc_sig_reg

//--- hdl/lbsc_capture.v
// Loopback signature capture for one channel lane set.
// Assumes host clocks, strobes and pins are asynchronous to
// core_clk and slow enough to be oversampled; command pulses,
// mode fields and test port controls are core_clk synchronous.
//
// What this block does
// - Signature mode samples cmd/addr on host clock, data on strobes.
// - Mask instruction forces selected signature inputs to zero.
// - Cmd/addr enable with mode 000 presets register and arms filter.
// - Cmd/addr mode 011 compresses, mode 010 stores raw.
// - First cmd/addr cycle after preset is discarded; rest captured.
// - Write parity keeps being checked in capture modes when enabled.
// - Data test traffic uses normal writes, latency and burst length.
// - Register mode stores rising and falling samples, two bits each.
// - Register mode keeps only the last double-rate cycle.
// - Data register mode works without any preceding preset.
// - Used filter stays off until next preset; preset overwrites seed.
// - Select 11 returns static sticky compare bits per signal.
// - Select 01 returns data signature register contents.
// - Select 10 returns last cycle held in receive samplers.
// - Read-back needs loopback, register mode, select; normal reads.
// - Test port reads both signatures; cmd/addr only via test port.
// - Presets are AAAAAh for data and 2AAAAAAh for cmd/addr.
// - Strobe preamble and postamble states are never captured.
`timescale 1ns/1ns
`include "lbsc_map.vh"
module lbsc_capture (
  input wire core_clk, // core clock, 100 MHz
  input wire rst, // async reset, active high
  input wire hostClockTrue, // host clock true phase pin
  input wire hostClockComp, // host clock complement pin
  input wire [12:0] cmdAddrGroup, // cmd/addr group pins
  input wire cmdAddrParity, // cmd/addr parity pin
  input wire writeStrobeTrue, // write strobe true pin
  input wire writeStrobeComp, // write strobe complement pin
  input wire [9:0] dataLaneGroup, // data lane group pins
  input wire dataParity, // data parity pin
  input wire caCaptureEnable, // cmd/addr capture enable
  input wire [2:0] caCaptureMode, // cmd/addr capture mode code
  input wire dataLoopbackEnable, // data loopback enable
  input wire [2:0] dataCaptureControl, // data capture mode code
  input wire [1:0] readbackSelect, // read-back source select
  input wire parityCheckEnable, // write parity check enable
  input wire writeCmd, // write command accepted pulse
  input wire [3:0] writeLatency, // write latency, host cycles
  input wire burstLen4, // 1: burst of 4, 0: burst of 2
  input wire readCmd, // read command accepted pulse
  input wire [9:0] dataMiscompare, // compare logic miss pulses
  input wire [1:0] tpInstr, // test port instruction
  input wire tpUpdate, // test port update pulse
  input wire tpCapture, // test port capture pulse
  input wire [25:0] tpDataIn, // test port shift-in word
  output reg [25:0] tpDataOut_q, // test port capture word
  output reg [9:0] readbackRise_q, // read-back rising data
  output reg [9:0] readbackFall_q, // read-back falling data
  output reg readbackValid_q, // read-back source active
  output reg caParityErr_q, // cmd/addr parity error pulse
  output reg dataParityErr_q, // data parity error pulse
  output reg caFilterArmed_q // preamble filter armed
);
  // ----------------------------------------------------------------
  // Write window states
  // ----------------------------------------------------------------
  localparam ST_IDLE = 2'b00;
  localparam ST_LAT = 2'b01;
  localparam ST_BURST = 2'b10;

  // ----------------------------------------------------------------
  // Pin synchronisation and edge detection
  // ----------------------------------------------------------------
  wire [28:0] pinRaw;
  wire [28:0] pinSync;
  reg [3:0] clkPrev_q;
  wire htRise;
  wire hcRise;
  wire wtRise;
  wire wcRise;
  wire [12:0] caPins;
  wire caPar;
  wire [9:0] dPins;
  wire dPar;

  assign pinRaw = {dataParity, dataLaneGroup, cmdAddrParity,
    cmdAddrGroup, ~writeStrobeComp, writeStrobeTrue, ~hostClockComp,
    hostClockTrue};

  lbsc_sync #(
    .W(`LBSC_SYNC_W)
  ) uPinSync (
    .clk(core_clk),
    .rst(rst),
    .din(pinRaw),
    .dout_q(pinSync)
  );

  assign htRise = pinSync[0] & ~clkPrev_q[0];
  assign hcRise = ~pinSync[1] & clkPrev_q[1];
  assign wtRise = pinSync[2] & ~clkPrev_q[2];
  assign wcRise = ~pinSync[3] & clkPrev_q[3];
  assign caPins = pinSync[16:4];
  assign caPar = pinSync[17];
  assign dPins = pinSync[27:18];
  assign dPar = pinSync[28];

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  wire caPreset;
  wire caRegMode;
  wire caSigMode;
  wire caActive;
  wire dPreset;
  wire dRegMode;
  wire dSigMode;
  wire dActive;

  assign caPreset = caCaptureEnable &&
    (caCaptureMode == `LBSC_MODE_PRESET);
  assign caRegMode = caCaptureEnable &&
    (caCaptureMode == `LBSC_MODE_REG);
  assign caSigMode = caCaptureEnable &&
    (caCaptureMode == `LBSC_MODE_SIG);
  assign caActive = caRegMode | caSigMode;
  assign dPreset = dataLoopbackEnable &&
    (dataCaptureControl == `LBSC_MODE_PRESET);
  // No preset dependency: raw store works from any prior state
  assign dRegMode = dataLoopbackEnable &&
    (dataCaptureControl == `LBSC_MODE_REG);
  assign dSigMode = dataLoopbackEnable &&
    (dataCaptureControl == `LBSC_MODE_SIG);
  assign dActive = dRegMode | dSigMode;

  // ----------------------------------------------------------------
  // Preamble filter for the command/address group
  // ----------------------------------------------------------------
  // Filter consumes both edges of the first host cycle; it is not
  // re-armed by a clock restart, only by another preset.
  reg caSkipFall_q;
  wire caRiseEn;
  wire caFallEn;

  assign caRiseEn = caActive & htRise & ~caFilterArmed_q;
  assign caFallEn = caActive & hcRise & ~caSkipFall_q;

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      caFilterArmed_q <= 1'b0;
      caSkipFall_q <= 1'b0;
    end
    else if (caPreset)
    begin
      caFilterArmed_q <= 1'b1;
      caSkipFall_q <= 1'b0;
    end
    else if (caActive && htRise && caFilterArmed_q)
    begin
      caFilterArmed_q <= 1'b0;
      caSkipFall_q <= 1'b1;
    end
    else if (caActive && hcRise && caSkipFall_q)
      caSkipFall_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Write window: latency in host cycles, then burst strobe edges
  // ----------------------------------------------------------------
  // One write in flight; a second command during a window is
  // ignored, which normal write spacing never produces.
  reg [1:0] wrState_q;
  reg [1:0] wrState_d;
  reg [3:0] latCnt_q;
  reg [3:0] latCnt_d;
  reg [1:0] burstLeft_q;
  reg [1:0] burstLeft_d;
  reg fallPend_q;
  reg fallPend_d;
  wire dRiseEn;
  wire dFallEn;
  wire [1:0] burstCycles;

  assign burstCycles = burstLen4 ? 2'h2 : 2'h1;
  // Only strobe edges inside the burst window reach the samplers
  assign dRiseEn = (wrState_q == ST_BURST) & wtRise &
    ~fallPend_q;
  assign dFallEn = fallPend_q & wcRise;

  always @*
  begin
    wrState_d = wrState_q;
    latCnt_d = latCnt_q;
    burstLeft_d = burstLeft_q;
    fallPend_d = fallPend_q;
    case (wrState_q)
      ST_IDLE:
      begin
        if (writeCmd)
        begin
          latCnt_d = writeLatency;
          if (writeLatency == 4'h0)
          begin
            burstLeft_d = burstCycles;
            wrState_d = ST_BURST;
          end
          else
            wrState_d = ST_LAT;
        end
      end
      ST_LAT:
      begin
        if (htRise)
        begin
          latCnt_d = latCnt_q - 4'h1;
          if (latCnt_q == 4'h1)
          begin
            burstLeft_d = burstCycles;
            wrState_d = ST_BURST;
          end
        end
      end
      ST_BURST:
      begin
        if (dRiseEn)
          fallPend_d = 1'b1;
        else if (dFallEn)
        begin
          fallPend_d = 1'b0;
          burstLeft_d = burstLeft_q - 2'h1;
          if (burstLeft_q == 2'h1)
            wrState_d = ST_IDLE;
        end
      end
      default:
      begin
        wrState_d = ST_IDLE;
        fallPend_d = 1'b0;
      end
    endcase
  end

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      wrState_q <= ST_IDLE;
      latCnt_q <= 4'h0;
      burstLeft_q <= 2'h0;
      fallPend_q <= 1'b0;
      clkPrev_q <= 4'h0;
    end
    else
    begin
      wrState_q <= wrState_d;
      latCnt_q <= latCnt_d;
      burstLeft_q <= burstLeft_d;
      fallPend_q <= fallPend_d;
      clkPrev_q <= pinSync[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Input masks from the test port
  // ----------------------------------------------------------------
  reg [12:0] caMask_q;
  reg [9:0] dMask_q;
  wire [12:0] caIn;
  wire [9:0] dIn;

  assign caIn = caPins & ~caMask_q;
  assign dIn = dPins & ~dMask_q;

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      caMask_q <= 13'h0000;
      dMask_q <= 10'h000;
    end
    else if (tpUpdate && tpInstr == `LBSC_TP_MASK)
    begin
      caMask_q <= tpDataIn[`LBSC_MASK_CA_LSB +: 13];
      dMask_q <= tpDataIn[`LBSC_MASK_D_LSB +: 10];
    end
  end

  // ----------------------------------------------------------------
  // Signature registers
  // ----------------------------------------------------------------
  wire [25:0] caSig;
  wire [19:0] dSig;

  // Rising bits take true edges, falling bits complement edges
  lbsc_sig_reg #(
    .N(`LBSC_CA_N),
    .PRESET(`LBSC_CA_PRESET)
  ) uCaSig (
    .clk(core_clk),
    .rst(rst),
    .preset(caPreset),
    .sigMode(caSigMode),
    .regMode(caRegMode),
    .riseEn(caRiseEn),
    .fallEn(caFallEn),
    .riseIn(caIn),
    .fallIn(caIn),
    .sig_q(caSig)
  );

  lbsc_sig_reg #(
    .N(`LBSC_D_N),
    .PRESET(`LBSC_D_PRESET)
  ) uDSig (
    .clk(core_clk),
    .rst(rst),
    .preset(dPreset),
    .sigMode(dSigMode),
    .regMode(dRegMode),
    .riseEn(dRiseEn & dActive),
    .fallEn(dFallEn & dActive),
    .riseIn(dIn),
    .fallIn(dIn),
    .sig_q(dSig)
  );

  // ----------------------------------------------------------------
  // Receive samplers, sticky bits and parity checks
  // ----------------------------------------------------------------
  reg [9:0] rxRise_q;
  reg [9:0] rxFall_q;
  reg [9:0] sticky_q;
  reg [9:0] sticky_d;

  // Preset clears, but a miss in the same cycle still lands
  always @*
  begin
    sticky_d = dPreset ? 10'h000 : sticky_q;
    sticky_d = sticky_d | dataMiscompare;
  end

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rxRise_q <= 10'h000;
      rxFall_q <= 10'h000;
      sticky_q <= 10'h000;
      caParityErr_q <= 1'b0;
      dataParityErr_q <= 1'b0;
    end
    else
    begin
      sticky_q <= sticky_d;
      if (dRiseEn)
        rxRise_q <= dPins;
      if (dFallEn)
        rxFall_q <= dPins;
      // Even parity over group plus parity pin
      caParityErr_q <= parityCheckEnable & (caRiseEn | caFallEn) &
        (^{caPins, caPar});
      dataParityErr_q <= parityCheckEnable & (dRiseEn | dFallEn) &
        (^{dPins, dPar});
    end
  end

  // ----------------------------------------------------------------
  // Functional read-back
  // ----------------------------------------------------------------
  // Data is latched at the read command and stays put for the
  // whole burst; the normal read path applies latency and strobes.
  wire rbEnable;
  integer k;

  assign rbEnable = dRegMode && (readbackSelect != 2'h0);

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      readbackRise_q <= 10'h000;
      readbackFall_q <= 10'h000;
      readbackValid_q <= 1'b0;
    end
    else
    begin
      readbackValid_q <= rbEnable;
      if (readCmd && rbEnable)
      begin
        case (readbackSelect)
          `LBSC_RB_SIG:
          begin
            for (k = 0; k < 10; k = k + 1)
            begin
              readbackRise_q[k] <= dSig[2*k];
              readbackFall_q[k] <= dSig[2*k+1];
            end
          end
          `LBSC_RB_RX:
          begin
            readbackRise_q <= rxRise_q;
            readbackFall_q <= rxFall_q;
          end
          `LBSC_RB_STICKY:
          begin
            readbackRise_q <= sticky_q;
            readbackFall_q <= sticky_q;
          end
          default:
          begin
            readbackRise_q <= readbackRise_q;
            readbackFall_q <= readbackFall_q;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Test port capture
  // ----------------------------------------------------------------
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      tpDataOut_q <= 26'h0000000;
    else if (tpCapture)
    begin
      case (tpInstr)
        `LBSC_TP_CA_SIG: tpDataOut_q <= caSig;
        `LBSC_TP_D_SIG: tpDataOut_q <= {6'h00, dSig};
        `LBSC_TP_STICKY: tpDataOut_q <= {16'h0000, sticky_q};
        `LBSC_TP_MASK: tpDataOut_q <= {3'h0, dMask_q, caMask_q};
        default: tpDataOut_q <= 26'h0000000;
      endcase
    end
  end
endmodule // lbsc_capture

//--- tb/lbsc_capture_assertions.sv
// Port-level checker for the capture block, bound below.
// Assumes one core clock domain with async active-high reset.
`timescale 1ns/1ns
module lbsc_chk (
  input wire core_clk, // core clock
  input wire rst, // async reset
  input wire caCaptureEnable, // ca enable
  input wire [2:0] caCaptureMode, // ca mode
  input wire dataLoopbackEnable, // loopback
  input wire [2:0] dataCaptureControl, // data mode
  input wire [1:0] readbackSelect, // rb source
  input wire parityCheckEnable, // parity on
  input wire readCmd, // read pulse
  input wire [1:0] tpInstr, // tp instruction
  input wire tpCapture, // tp capture
  input wire [25:0] tpDataOut_q, // tp word
  input wire [9:0] readbackRise_q, // rb rise
  input wire [9:0] readbackFall_q, // rb fall
  input wire readbackValid_q, // rb valid
  input wire caParityErr_q, // ca parity
  input wire dataParityErr_q, // data parity
  input wire caFilterArmed_q // filter armed
);
  wire caPre = caCaptureEnable && caCaptureMode == 3'h0;
  wire rbOk = dataLoopbackEnable && dataCaptureControl == 3'h2
    && readbackSelect != 2'h0;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  AST_PRESET_ARMS: assert property (
    caPre |=> caFilterArmed_q) else $error("preset left filter off");
  AST_ARM_CAUSE: assert property (
    $rose(caFilterArmed_q) |-> $past(caPre))
    else $error("filter armed without preset");
  AST_DISARM_CAUSE: assert property (
    $fell(caFilterArmed_q) |-> !$past(caPre))
    else $error("filter cleared during preset");
  AST_RB_VALID: assert property (
    readbackValid_q == $past(rbOk)) else $error("readback valid wrong");
  AST_STICKY_STATIC: assert property (
    readCmd && rbOk && readbackSelect == 2'h3
    |=> readbackRise_q == readbackFall_q)
    else $error("sticky data not static");
  AST_RB_STANDS: assert property (
    !readCmd |=> $stable({readbackRise_q, readbackFall_q}))
    else $error("readback data moved without read");
  AST_PARITY_OFF: assert property (
    !parityCheckEnable [*2] |-> !dataParityErr_q && !caParityErr_q)
    else $error("parity error while checking off");
  AST_PARITY_PULSE: assert property (
    dataParityErr_q || caParityErr_q
    |=> !dataParityErr_q && !caParityErr_q)
    else $error("parity error longer than one cycle");
  AST_MASK_WORD: assert property (
    tpCapture && tpInstr == 2'h1 |=> tpDataOut_q[25:23] == 3'h0)
    else $error("mask word upper bits set");
endmodule // lbsc_chk
bind lbsc_capture lbsc_chk i_chk (.core_clk(core_clk), .rst(rst),
  .caCaptureEnable(caCaptureEnable), .caCaptureMode(caCaptureMode),
  .dataLoopbackEnable(dataLoopbackEnable),
  .dataCaptureControl(dataCaptureControl),
  .readbackSelect(readbackSelect), .readCmd(readCmd),
  .parityCheckEnable(parityCheckEnable), .tpInstr(tpInstr),
  .tpCapture(tpCapture), .tpDataOut_q(tpDataOut_q),
  .readbackRise_q(readbackRise_q), .readbackFall_q(readbackFall_q),
  .readbackValid_q(readbackValid_q), .caParityErr_q(caParityErr_q),
  .dataParityErr_q(dataParityErr_q), .caFilterArmed_q(caFilterArmed_q));

//--- tb/lbsc_host.sv
// Host pin model: cmd/addr cycles and write data strobe pairs.
// Assumes the device oversamples the pins with its core clock.
`timescale 1ns/1ns
module lbsc_host (
  output logic hostClockTrue, // clock true
  output logic hostClockComp, // clock comp
  output logic [12:0] cmdAddrGroup, // ca pins
  output logic cmdAddrParity, // ca parity
  output logic writeStrobeTrue, // strobe true
  output logic writeStrobeComp, // strobe comp
  output logic [9:0] dataLaneGroup, // data pins
  output logic dataParity // data parity
);
  // ------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------
  initial
  begin
    {hostClockTrue, hostClockComp} = 2'b01;
    {writeStrobeTrue, writeStrobeComp} = 2'b01;
    cmdAddrGroup = 13'h0000;
    cmdAddrParity = 1'b0;
    dataLaneGroup = 10'h000;
    dataParity = 1'b0;
  end
  task put(input d, input [12:0] v, input b);
  begin
    if (d)
    begin
      dataLaneGroup = v[9:0];
      dataParity = ^v[9:0] ^ b;
    end
    else
    begin
      cmdAddrGroup = v;
      cmdAddrParity = ^v ^ b;
    end
  end
  endtask
  task edg(input d, input x);
  begin
    if (d)
      {writeStrobeTrue, writeStrobeComp} = {x, !x};
    else
      {hostClockTrue, hostClockComp} = {x, !x};
  end
  endtask
  // Clock stops true low; pins then show inverted data, not held
  task ddr(input d, input [12:0] r, input [12:0] f, input b);
  begin
    put(d, r, b);
    #31 edg(d, 1'b1);
    #31 put(d, f, b);
    #31 edg(d, 1'b0);
    #32 put(d, ~f, b);
  end
  endtask
endmodule // lbsc_host

//--- tb/lbsc_capture_tb.sv
// Self-checking bench for the loopback signature capture block.
// Assumes the host pin model drives the link side.
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin \
  err_total++; $display("mismatch t=%0t got=%0h exp=%0h", \
  $time, g, e); end end
module lbsc_capture_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic hostClockTrue, hostClockComp, cmdAddrParity;
  logic writeStrobeTrue, writeStrobeComp, dataParity;
  logic [12:0] cmdAddrGroup;
  logic [9:0] dataLaneGroup, readbackRise_q, readbackFall_q;
  logic [9:0] dataMiscompare = 10'h000;
  logic caCaptureEnable = 1'b0, dataLoopbackEnable = 1'b0;
  logic [2:0] caCaptureMode = 3'h0, dataCaptureControl = 3'h0;
  logic [1:0] readbackSelect = 2'h0, tpInstr = 2'h0;
  logic parityCheckEnable = 1'b0, writeCmd = 1'b0, burstLen4 = 1'b0;
  logic readCmd = 1'b0, tpUpdate = 1'b0, tpCapture = 1'b0;
  logic [3:0] writeLatency = 4'h0;
  logic [25:0] tpDataIn = 26'h0000000, tpDataOut_q;
  logic readbackValid_q, caParityErr_q, dataParityErr_q, caFilterArmed_q;
  integer err_total = 0, compares = 0, parCnt = 0, caCnt = 0;
  initial
    forever #5 core_clk = ~core_clk;
  lbsc_host i_lbsc_host (.hostClockTrue, .hostClockComp, .cmdAddrGroup,
    .cmdAddrParity, .writeStrobeTrue, .writeStrobeComp, .dataLaneGroup,
    .dataParity);
  lbsc_capture i_lbsc_capture (.core_clk, .rst, .hostClockTrue,
    .hostClockComp, .cmdAddrGroup, .cmdAddrParity, .writeStrobeTrue,
    .writeStrobeComp, .dataLaneGroup, .dataParity, .caCaptureEnable,
    .caCaptureMode, .dataLoopbackEnable, .dataCaptureControl,
    .readbackSelect, .parityCheckEnable, .writeCmd, .writeLatency,
    .burstLen4, .readCmd, .dataMiscompare, .tpInstr, .tpUpdate,
    .tpCapture, .tpDataIn, .tpDataOut_q, .readbackRise_q,
    .readbackFall_q, .readbackValid_q, .caParityErr_q, .dataParityErr_q,
    .caFilterArmed_q);
  always @(posedge core_clk)
  begin
    parCnt += (dataParityErr_q === 1'b1);
    caCnt += (caParityErr_q === 1'b1);
  end
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic [25:0] il(input [12:0] r, input [12:0] f);
    integer i;
    for (i = 0; i < 13; i++)
    begin
      il[2*i] = r[i];
      il[2*i+1] = f[i];
    end
  endfunction
  function automatic [25:0] cmp(input [25:0] s, input [12:0] v,
    input integer o);
    integer i;
    cmp = {s[24:0], s[25] ^ s[23]};
    for (i = 0; i < 13; i++)
      cmp[2*i+o] = cmp[2*i+o] ^ v[i];
  endfunction
  task tick(input integer n);
    repeat (n) @(posedge core_clk);
  endtask
  task tpRd(input [1:0] ins, input [25:0] e);
  begin
    tick(1);
    tpInstr <= ins;
    tpCapture <= 1'b1;
    tick(1);
    tpCapture <= 1'b0;
    tick(2);
    `CHK(tpDataOut_q, e)
  end
  endtask
  task rdBack(input [1:0] s, input [9:0] er, input [9:0] ef);
  begin
    tick(1);
    readbackSelect <= s;
    tick(2);
    readCmd <= 1'b1;
    tick(1);
    readCmd <= 1'b0;
    tick(2);
    `CHK(readbackValid_q, 1'b1)
    `CHK(readbackRise_q, er)
    `CHK(readbackFall_q, ef)
  end
  endtask
  // All-ones postamble would show if captured
  task wr(input [9:0] r0, f0, r1, f1, input b, p);
  begin
    tick(1);
    writeCmd <= 1'b1;
    tick(1);
    writeCmd <= 1'b0;
    i_lbsc_host.ddr(1'b1, {3'h0, r0}, {3'h0, f0}, 1'b0);
    i_lbsc_host.ddr(1'b1, {3'h0, r1}, {3'h0, f1}, b);
    if (p)
      i_lbsc_host.ddr(1'b1, 13'h03FF, 13'h03FF, 1'b0);
    tick(8);
  end
  endtask
  task finish_test;
  begin
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial
  begin
    tick(12);
    rst <= 1'b0;
    tpRd(2'h3, 26'h00AAAAA);
    tpRd(2'h2, 26'h2AAAAAA);
    parityCheckEnable <= 1'b1;
    caCaptureEnable <= 1'b1;
    tick(3);
    `CHK(caFilterArmed_q, 1'b1)
    caCaptureMode <= 3'h3;
    tick(2);
    i_lbsc_host.ddr(1'b0, 13'h1234, 13'h0F0F, 1'b0);
    i_lbsc_host.ddr(1'b0, 13'h0ABC, 13'h1111, 1'b0);
    tick(8);
    `CHK(caFilterArmed_q, 1'b0)
    tpRd(2'h2, cmp(cmp(26'h2AAAAAA, 13'h0ABC, 0), 13'h1111, 1));
    caCaptureMode <= 3'h2;
    i_lbsc_host.ddr(1'b0, 13'h1AAA, 13'h0555, 1'b0);
    tick(8);
    tpRd(2'h2, il(13'h1AAA, 13'h0555));
    i_lbsc_host.ddr(1'b0, 13'h0001, 13'h1000, 1'b1);
    tick(8);
    tpRd(2'h2, il(13'h0001, 13'h1000));
    dataLoopbackEnable <= 1'b1;
    caCaptureMode <= 3'h0;
    tick(3);
    `CHK(caFilterArmed_q, 1'b1)
    tpRd(2'h2, 26'h2AAAAAA);
    `CHK(caCnt, 2)
    dataCaptureControl <= 3'h3;
    wr(10'h001, 10'h200, 10'h3FF, 10'h3FF, 1'b0, 1'b0);
    tpRd(2'h3, 26'h002AAAA);
    burstLen4 <= 1'b1;
    dataCaptureControl <= 3'h2;
    wr(10'h3C3, 10'h0F0, 10'h155, 10'h2AA, 1'b0, 1'b1);
    tpRd(2'h3, il(13'h0155, 13'h02AA));
    `CHK(parCnt, 0)
    wr(10'h000, 10'h3FF, 10'h001, 10'h002, 1'b1, 1'b1);
    `CHK(parCnt, 2)
    tpInstr <= 2'h1;
    tpDataIn <= 26'h001E000;
    tpUpdate <= 1'b1;
    tick(1);
    tpUpdate <= 1'b0;
    tpRd(2'h1, 26'h001E000);
    wr(10'h000, 10'h000, 10'h3F5, 10'h0FA, 1'b0, 1'b0);
    tpRd(2'h3, il(13'h03F0, 13'h00F0));
    rdBack(2'h1, 10'h3F0, 10'h0F0);
    rdBack(2'h2, 10'h3F5, 10'h0FA);
    dataMiscompare <= 10'h205;
    tick(1);
    dataMiscompare <= 10'h000;
    rdBack(2'h3, 10'h205, 10'h205);
    finish_test;
  end
  // Well above test length
  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    finish_test;
  end
endmodule // lbsc_capture_tb
